// File: include/backup_regs_defines.svh
/*
 * Constants of the backup register bank: register offsets, field positions,
 * reset values and counter widths.
 * Assumes it is included by the package and by the design files.
 */
`ifndef BACKUP_REGS_DEFINES_SVH
`define BACKUP_REGS_DEFINES_SVH

`define ADDR_W 8
`define BUS_W 32
`define REG_W 16
`define IDX_W 6

`define OFS_DATA_LO_FIRST 8'h04
`define OFS_DATA_LO_LAST 8'h28
`define OFS_CALIB 8'h2C
`define OFS_TAMPER_CTL 8'h30
`define OFS_TAMPER_STAT 8'h34
`define OFS_DATA_HI_FIRST 8'h40
`define OFS_DATA_HI_LAST 8'hBC

`define NUM_DATA_SMALL 6'h0A
`define NUM_DATA_LARGE 42
`define WORD_SHIFT 2
`define REG_RESET 16'h0000

`define CAL_VAL_W 7
`define CAL_VAL_MSB 6
`define CAL_CCO_BIT 7
`define CAL_PULSE_EN_BIT 8
`define CAL_PULSE_SEL_BIT 9
`define CTL_ENABLE_BIT 0
`define CTL_LEVEL_BIT 1
`define STAT_CLEAR_BIT 0
`define STAT_IRQ_EN_BIT 2
`define STAT_FLAG_BIT 8

`define CAL_WINDOW_W 20
`define CAL_DIV_W 6

`endif

// File: include/backup_regs_pkg.sv
/*
 * Types of the backup register bank: the state records of each module.
 * Assumes the defines header is on the include path.
 */
`include "backup_regs_defines.svh"

package backup_regs_pkg;

   typedef logic [`REG_W-1:0] word_t;

   typedef struct packed {
      word_t [`NUM_DATA_LARGE-1:0] data;
      logic [`CAL_VAL_W-1:0] cal_value;
      logic calib_clock_out;
      logic pulse_out_enable;
      logic pulse_out_select;
      logic tamper_detect_enable;
      logic tamper_active_level;
      logic tamper_irq_enable;
      logic tamper_event_flag;
      logic pin_s1;
      logic pin_s2;
      logic sup_s1;
      logic sup_s2;
      logic [`BUS_W-1:0] rdata;
      logic irq;
      logic pin_out;
      logic pin_oe_n;
      logic gpio_free;
   } top_state_t;

   localparam top_state_t TOP_RESET = '{pin_oe_n: 1'b1, gpio_free: 1'b1, default: '0};

   typedef struct packed {
      logic gated_prev;
      logic event_pulse;
   } det_state_t;

   typedef struct packed {
      logic [`CAL_WINDOW_W-1:0] window;
      logic [`CAL_DIV_W-1:0] div;
      logic clk_div;
   } cal_state_t;

endpackage

// File: include/backup_link_if.sv
/*
 * Carrier between the register bank and its tamper detector and calibrator.
 * Assumes all three parties share one clock.
 */
`timescale 1ns/1ps
`default_nettype none
`include "backup_regs_defines.svh"

interface backup_link_if;
   logic tamper_en;
   logic active_level;
   logic pin_level;
   logic tamper_event;
   logic [`CAL_VAL_W-1:0] cal_value;
   logic calib_clk;

   modport bank (output tamper_en, active_level, pin_level, cal_value,
                 input tamper_event, calib_clk);
   modport det (input tamper_en, active_level, pin_level, output tamper_event);
   modport cal (input cal_value, output calib_clk);
endinterface

`default_nettype wire

// File: rtl/tamper_edge_detect.sv
/*
 * Tamper edge detector: gated pin level, one-cycle event on its rise.
 * Assumes the pin level is already synchronised.
 */
`timescale 1ns/1ps
`default_nettype none

module tamper_edge_detect
   import backup_regs_pkg::*;
(
   // Clock and control
   input wire logic ref_clk_in,
   input wire logic sys_rst_in,
   input wire logic ce_in,
   // Bank side
   backup_link_if.det link
);

   det_state_t r_reg;
   det_state_t r_next;
   logic gated;

   always_comb begin
      // Level 1 inverts the pin, so the gated signal always rises toward tamper
      gated = link.tamper_en & (link.pin_level ^ link.active_level);
      r_next = r_reg;
      r_next.gated_prev = gated;
      r_next.event_pulse = gated & ~r_reg.gated_prev;
   end

   always_ff @(posedge ref_clk_in) begin
      if (sys_rst_in) begin
         r_reg <= '0;
      end else if (ce_in) begin
         r_reg <= r_next;
      end
   end

   assign link.tamper_event = r_reg.event_pulse;

endmodule

`default_nettype wire

// File: rtl/calib_clock_gen.sv
/*
 * Calibrated divide-by-64 clock: drops cal_value input pulses per window.
 * Assumes the module clock is the RTC clock.
 */
`timescale 1ns/1ps
`default_nettype none
`include "backup_regs_defines.svh"

module calib_clock_gen
   import backup_regs_pkg::*;
(
   // Clock and control
   input wire logic ref_clk_in,
   input wire logic sys_rst_in,
   input wire logic ce_in,
   // Bank side
   backup_link_if.cal link
);

   cal_state_t r_reg;
   cal_state_t r_next;

   always_comb begin
      r_next = r_reg;
      r_next.window = r_reg.window + 1'b1;
      // The first cal_value pulses of each window never reach the divider
      if (r_reg.window >= `CAL_WINDOW_W'(link.cal_value)) begin
         r_next.div = r_reg.div + 1'b1;
      end
      r_next.clk_div = r_reg.div[`CAL_DIV_W-1];
   end

   always_ff @(posedge ref_clk_in) begin
      if (sys_rst_in) begin
         r_reg <= '0;
      end else if (ce_in) begin
         r_reg <= r_next;
      end
   end

   assign link.calib_clk = r_reg.clk_div;

endmodule

`default_nettype wire

// File: rtl/backup_regs_tamper_calib.sv
/*
 * Backup register bank: user data words, tamper detection, calibration
 * control and the shared pin output.
 * Assumes ref_clk_in is the backup-domain clock and sys_rst_in the
 * backup-domain reset; the write unlock comes from logic on this clock.
 */
`timescale 1ns/1ps
`default_nettype none
`include "backup_regs_defines.svh"

module backup_regs_tamper_calib
   import backup_regs_pkg::*;
#(
   parameter bit LARGE_VARIANT = 1'b1
)
(
   // Clock, reset and enable
   input wire logic ref_clk_in,
   input wire logic sys_rst_in,
   input wire logic ce_in,
   // Register port
   input wire logic [`ADDR_W-1:0] addr_in,
   input wire logic [`BUS_W-1:0] wdata_in,
   input wire logic wr_in,
   input wire logic rd_in,
   output logic [`BUS_W-1:0] rdata_out,
   // Power control
   input wire logic backup_write_unlock_in,
   input wire logic main_supply_off_in,
   // RTC pulses
   input wire logic rtc_alarm_pulse_in,
   input wire logic rtc_second_pulse_in,
   // Tamper pin
   input wire logic tamper_pin_in,
   output logic tamper_pin_out,
   output logic tamper_pin_oe_n_out,
   output logic pin_gpio_free_out,
   // Interrupt request
   output logic tamper_irq_out
);

   localparam logic [`IDX_W-1:0] NUM_DATA =
      LARGE_VARIANT ? `IDX_W'(`NUM_DATA_LARGE) : `NUM_DATA_SMALL;

   top_state_t r_reg;
   top_state_t r_next;

   backup_link_if link ();

   tamper_edge_detect u_detect (
      .ref_clk_in(ref_clk_in),
      .sys_rst_in(sys_rst_in),
      .ce_in(ce_in),
      .link(link.det)
   );

   calib_clock_gen u_calib (
      .ref_clk_in(ref_clk_in),
      .sys_rst_in(sys_rst_in),
      .ce_in(ce_in),
      .link(link.cal)
   );

   assign link.tamper_en = r_reg.tamper_detect_enable;
   assign link.active_level = r_reg.tamper_active_level;
   assign link.pin_level = r_reg.pin_s2;
   assign link.cal_value = r_reg.cal_value;

   // Word-aligned decode; a half-word at offset +2 is the upper half of the
   // 32-bit word holding a 16-bit register, which reads zero and ignores writes
   logic aligned;
   logic hit_lo;
   logic hit_hi;
   logic hit_data;
   logic [`ADDR_W-1:0] rel_addr;
   logic [`IDX_W-1:0] data_idx;
   logic [`REG_W-1:0] wr_half;
   logic wr_ok;
   logic tamper_hit;
   word_t data_rd;

   always_comb begin
      aligned = (addr_in[`WORD_SHIFT-1:0] == '0);
      hit_lo = aligned && addr_in >= `OFS_DATA_LO_FIRST && addr_in <= `OFS_DATA_LO_LAST;
      hit_hi = aligned && addr_in >= `OFS_DATA_HI_FIRST && addr_in <= `OFS_DATA_HI_LAST;
      rel_addr = '0;
      data_idx = '0;
      if (hit_lo) begin
         rel_addr = addr_in - `OFS_DATA_LO_FIRST;
         data_idx = `IDX_W'(rel_addr >> `WORD_SHIFT);
      end else if (hit_hi) begin
         rel_addr = addr_in - `OFS_DATA_HI_FIRST;
         data_idx = `IDX_W'(rel_addr >> `WORD_SHIFT) + `NUM_DATA_SMALL;
      end
      // The small variant has no upper block
      hit_data = (hit_lo || hit_hi) && (data_idx < NUM_DATA);
      data_rd = r_reg.data[data_idx];
      wr_half = wdata_in[`REG_W-1:0];
      // Locked until the power controller opens the backup domain
      wr_ok = wr_in && backup_write_unlock_in;
   end

   always_comb begin
      r_next = r_reg;

      // Two-flop synchronisers for the pin and the supply indication
      r_next.pin_s1 = tamper_pin_in;
      r_next.pin_s2 = r_reg.pin_s1;
      r_next.sup_s1 = main_supply_off_in;
      r_next.sup_s2 = r_reg.sup_s1;

      // Register writes
      if (wr_ok && aligned) begin
         if (hit_data && !r_reg.tamper_event_flag) begin
            r_next.data[data_idx] = wr_half;
         end
         case (addr_in)
            `OFS_CALIB: begin
               r_next.cal_value = wr_half[`CAL_VAL_MSB:0];
               r_next.calib_clock_out = wr_half[`CAL_CCO_BIT];
               r_next.pulse_out_enable = wr_half[`CAL_PULSE_EN_BIT];
               r_next.pulse_out_select = wr_half[`CAL_PULSE_SEL_BIT];
            end
            `OFS_TAMPER_CTL: begin
               r_next.tamper_detect_enable = wr_half[`CTL_ENABLE_BIT];
               r_next.tamper_active_level = wr_half[`CTL_LEVEL_BIT];
            end
            `OFS_TAMPER_STAT: begin
               r_next.tamper_irq_enable = wr_half[`STAT_IRQ_EN_BIT];
               if (wr_half[`STAT_CLEAR_BIT]) begin
                  r_next.tamper_event_flag = 1'b0;
               end
            end
            default: begin
            end
         endcase
      end

      // Main supply loss drops the clock output; this path needs no
      // backup-domain reset
      if (r_reg.sup_s2) begin
         r_next.calib_clock_out = 1'b0;
      end

      // Tamper event: works regardless of main supply; set beats clear
      tamper_hit = link.tamper_event && r_reg.tamper_detect_enable;
      if (tamper_hit) begin
         r_next.tamper_event_flag = 1'b1;
      end
      if (tamper_hit || r_reg.tamper_event_flag) begin
         for (int i = 0; i < `NUM_DATA_LARGE; i++) begin
            r_next.data[i] = `REG_RESET;
         end
      end
      r_next.irq = tamper_hit && r_reg.tamper_irq_enable;

      // Read data stand for the cycle after the strobe only
      r_next.rdata = '0;
      if (rd_in && aligned) begin
         if (hit_data) begin
            r_next.rdata[`REG_W-1:0] = data_rd;
         end else begin
            case (addr_in)
               `OFS_CALIB: begin
                  r_next.rdata[`CAL_VAL_MSB:0] = r_reg.cal_value;
                  r_next.rdata[`CAL_CCO_BIT] = r_reg.calib_clock_out;
                  r_next.rdata[`CAL_PULSE_EN_BIT] = r_reg.pulse_out_enable;
                  r_next.rdata[`CAL_PULSE_SEL_BIT] = r_reg.pulse_out_select;
               end
               `OFS_TAMPER_CTL: begin
                  r_next.rdata[`CTL_ENABLE_BIT] = r_reg.tamper_detect_enable;
                  r_next.rdata[`CTL_LEVEL_BIT] = r_reg.tamper_active_level;
               end
               `OFS_TAMPER_STAT: begin
                  r_next.rdata[`STAT_IRQ_EN_BIT] = r_reg.tamper_irq_enable;
                  r_next.rdata[`STAT_FLAG_BIT] = r_reg.tamper_event_flag;
               end
               default: begin
               end
            endcase
         end
      end

      // Shared pin: calibration clock first, then the RTC pulses.
      // Detection is not suppressed here; software keeps it off meanwhile.
      r_next.gpio_free = ~r_reg.tamper_detect_enable;
      r_next.pin_oe_n = 1'b1;
      r_next.pin_out = 1'b0;
      if (r_reg.calib_clock_out) begin
         r_next.pin_oe_n = 1'b0;
         r_next.pin_out = link.calib_clk;
      end else if (r_reg.pulse_out_enable) begin
         r_next.pin_oe_n = 1'b0;
         r_next.pin_out = r_reg.pulse_out_select ? rtc_second_pulse_in
                                                 : rtc_alarm_pulse_in;
      end
   end

   // Only the backup-domain reset reaches this state; system resets and
   // standby wakeups are not inputs of this block
   always_ff @(posedge ref_clk_in) begin
      if (sys_rst_in) begin
         r_reg <= TOP_RESET;
      end else if (ce_in) begin
         r_reg <= r_next;
      end
   end

   assign rdata_out = r_reg.rdata;
   assign tamper_pin_out = r_reg.pin_out;
   assign tamper_pin_oe_n_out = r_reg.pin_oe_n;
   assign pin_gpio_free_out = r_reg.gpio_free;
   assign tamper_irq_out = r_reg.irq;

endmodule

`default_nettype wire

// File: testbench/backup_regs_tamper_calib_assertions.sv
/* Port checker of the backup register bank, bound to its top module.
   Assumes ce_in stays high and the pin never mixes functions. */
`timescale 1ns/1ps
`default_nettype none
`include "backup_regs_defines.svh"
module backup_regs_tamper_calib_assertions #(
   parameter bit LARGE_VARIANT = 1'b1
)
(
   // Clock, reset and register port
   input wire logic ref_clk_in,
   input wire logic sys_rst_in,
   input wire logic [`ADDR_W-1:0] addr_in,
   input wire logic [`BUS_W-1:0] wdata_in,
   input wire logic wr_in,
   input wire logic rd_in,
   input wire logic [`BUS_W-1:0] rdata_out,
   // Power, pulse and pin
   input wire logic backup_write_unlock_in,
   input wire logic main_supply_off_in,
   input wire logic rtc_alarm_pulse_in,
   input wire logic tamper_pin_in,
   input wire logic tamper_pin_out,
   input wire logic tamper_pin_oe_n_out,
   input wire logic pin_gpio_free_out,
   input wire logic tamper_irq_out
);
   // Shadow of the control bits, rebuilt from writes seen at the port
   logic en_reg, lvl_reg, ie_reg, cco_reg, pe_reg, ps_reg, s1_reg, s2_reg;
   wire logic wok = wr_in && backup_write_unlock_in;
   always_ff @(posedge ref_clk_in) begin
      s1_reg <= main_supply_off_in;
      s2_reg <= s1_reg;
      if (sys_rst_in) begin
         {en_reg, lvl_reg, ie_reg, cco_reg, pe_reg, ps_reg} <= '0;
      end else begin
         if (wok && addr_in == `OFS_TAMPER_CTL) {lvl_reg, en_reg} <= wdata_in[1:0];
         if (wok && addr_in == `OFS_TAMPER_STAT) ie_reg <= wdata_in[`STAT_IRQ_EN_BIT];
         if (wok && addr_in == `OFS_CALIB) {ps_reg, pe_reg, cco_reg} <= wdata_in[9:7];
         // Supply loss wins, as the bank clears the bit after its own sync
         if (s2_reg) cco_reg <= 1'b0;
      end
   end
   default clocking @(posedge ref_clk_in); endclocking
   default disable iff (sys_rst_in);
   property p_rd_idle; !$past(rd_in) |-> rdata_out == '0; endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("read data out of slot");
   property p_irq_pulse; tamper_irq_out |=> !tamper_irq_out; endproperty
   a_irq_pulse: assert property (p_irq_pulse) else $error("irq too long");
   property p_irq_gate; tamper_irq_out |-> $past(ie_reg) && $past(en_reg, 2); endproperty
   a_irq_gate: assert property (p_irq_gate) else $error("irq without enables");
   property p_evt_rise; en_reg && !lvl_reg && ie_reg && $rose(tamper_pin_in) |-> ##[2:6] tamper_irq_out; endproperty
   a_evt_rise: assert property (p_evt_rise) else $error("rise missed");
   property p_gpio; $stable(en_reg) |-> pin_gpio_free_out == !en_reg; endproperty
   a_gpio: assert property (p_gpio) else $error("gpio flag wrong");
   property p_cco_on; $rose(cco_reg) |-> ##[0:2] !tamper_pin_oe_n_out; endproperty
   a_cco_on: assert property (p_cco_on) else $error("clock not driven");
   property p_supply; $rose(main_supply_off_in) && cco_reg && !pe_reg |-> ##[2:5] tamper_pin_oe_n_out; endproperty
   a_supply: assert property (p_supply) else $error("clock kept on supply loss");
   property p_alarm; pe_reg && !cco_reg && !ps_reg && rtc_alarm_pulse_in |=> tamper_pin_out ##1 !tamper_pin_out;
   endproperty
   a_alarm: assert property (p_alarm) else $error("alarm pulse wrong");
   c_irq: cover property (tamper_irq_out);
   c_cco: cover property ($rose(cco_reg));
   c_alarm: cover property (pe_reg && rtc_alarm_pulse_in);
endmodule
bind backup_regs_tamper_calib backup_regs_tamper_calib_assertions #(.LARGE_VARIANT(LARGE_VARIANT)) chk_i (
   .ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in), .addr_in(addr_in), .wdata_in(wdata_in),
   .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .backup_write_unlock_in(backup_write_unlock_in),
   .main_supply_off_in(main_supply_off_in), .rtc_alarm_pulse_in(rtc_alarm_pulse_in),
   .tamper_pin_in(tamper_pin_in), .tamper_pin_out(tamper_pin_out), .tamper_pin_oe_n_out(tamper_pin_oe_n_out),
   .pin_gpio_free_out(pin_gpio_free_out), .tamper_irq_out(tamper_irq_out));
`default_nettype wire

// File: testbench/tamper_switch_model.sv
/* Far side of the tamper pin: a switch to a rail over a pull-down, and
   an instrument timing the pin's rising edges. Assumes one clock. */
`timescale 1ns/1ps
`default_nettype none
module tamper_switch_model (
   // Clock and switch
   input wire logic ref_clk_in,
   input wire logic close_in,
   input wire logic rail_in,
   // Bank drive
   input wire logic drive_in,
   input wire logic drive_oe_n_in,
   // Pin and measurement
   output logic pin_out,
   output int period_out
);
   int count_reg = 0;
   logic prev_reg;
   // Undriven by the bank, an open switch leaves the line to its pull-down, never to a stale value
   assign pin_out = !drive_oe_n_in ? drive_in : (close_in ? rail_in : 1'b0);
   always_ff @(posedge ref_clk_in) begin
      prev_reg <= pin_out;
      count_reg <= count_reg + 1;
      if (pin_out && !prev_reg) begin
         period_out <= count_reg;
         count_reg <= 1;
      end
   end
endmodule
`default_nettype wire

// File: testbench/backup_regs_tamper_calib_bench.sv
/* Self-checking bench of the backup register bank with a register model.
   Assumes the checker is bound to the bank and a 125 MHz clock. */
`timescale 1ns/1ps
`default_nettype none
module backup_regs_tamper_calib_bench;
   logic ref_clk_in = 1'b0;
   logic sys_rst_in = 1'b1;
   logic [7:0] addr_in = 8'h00;
   logic [31:0] wdata_in = 32'h0;
   logic [31:0] rdata_out;
   logic wr_in = 1'b0, rd_in = 1'b0, backup_write_unlock_in = 1'b0, main_supply_off_in = 1'b0;
   logic rtc_alarm_pulse_in = 1'b0, rtc_second_pulse_in = 1'b0, sw_close = 1'b0, sw_rail = 1'b0;
   logic tamper_pin_in, tamper_pin_out, tamper_pin_oe_n_out, pin_gpio_free_out, tamper_irq_out;
   int period, bad_count = 0, num_checks = 0, cal_m = 0, ctl_m = 0, ie_m = 0, flag_m = 0, edge_n = 0;
   int dm[42] = '{default: 0};
   always #4 ref_clk_in = ~ref_clk_in;
   backup_regs_tamper_calib #(.LARGE_VARIANT(1'b1)) backup_regs_tamper_calib_i (
      .ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in), .ce_in(1'h1), .addr_in(addr_in),
      .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
      .backup_write_unlock_in(backup_write_unlock_in), .main_supply_off_in(main_supply_off_in),
      .rtc_alarm_pulse_in(rtc_alarm_pulse_in), .rtc_second_pulse_in(rtc_second_pulse_in),
      .tamper_pin_in(tamper_pin_in), .tamper_pin_out(tamper_pin_out),
      .tamper_pin_oe_n_out(tamper_pin_oe_n_out), .pin_gpio_free_out(pin_gpio_free_out),
      .tamper_irq_out(tamper_irq_out));
   tamper_switch_model tamper_switch_model_i (.ref_clk_in(ref_clk_in), .close_in(sw_close),
      .rail_in(sw_rail), .drive_in(tamper_pin_out), .drive_oe_n_in(tamper_pin_oe_n_out),
      .pin_out(tamper_pin_in), .period_out(period));
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   function automatic logic [31:0] exp_rd(input logic [7:0] a);
      if (a[1:0] != 2'h0) return 32'h0;
      if (a >= 8'h04 && a <= 8'h28) return 32'(dm[a / 4 - 1]);
      if (a >= 8'h40 && a <= 8'hBC) return 32'(dm[a / 4 - 6]);
      if (a == 8'h2C) return 32'(cal_m);
      if (a == 8'h30) return 32'(ctl_m);
      if (a == 8'h34) return 32'(flag_m * 256 + ie_m * 4);
      return 32'h0;
   endfunction
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      addr_in <= a;
      wdata_in <= d;
      wr_in <= 1'b1;
      @(posedge ref_clk_in);
      wr_in <= 1'b0;
      @(posedge ref_clk_in);
      if (!backup_write_unlock_in) return;
      if (a >= 8'h04 && a <= 8'h28 && flag_m == 0) dm[a / 4 - 1] = int'(d[15:0]);
      if (a >= 8'h40 && a <= 8'hBC && flag_m == 0) dm[a / 4 - 6] = int'(d[15:0]);
      if (a == 8'h2C) cal_m = int'(d[9:0]);
      if (a == 8'h30) ctl_m = int'(d[1:0]);
      if (a == 8'h34) ie_m = int'(d[2]);
      if (a == 8'h34 && d[0]) flag_m = 0;
   endtask
   task automatic rd(input logic [7:0] a);
      logic [31:0] v;
      addr_in <= a;
      rd_in <= 1'b1;
      @(posedge ref_clk_in);
      rd_in <= 1'b0;
      #1 v = rdata_out;
      @(posedge ref_clk_in);
      check(v, exp_rd(a));
   endtask
   task automatic rd_all;
      for (int i = 0; i <= 48; i++) rd(8'(i * 4));
      rd(8'h06);
   endtask
   // Waits long enough for a synchronised edge to reach the flag
   task automatic expect_event(input logic evt);
      logic seen;
      seen = 1'b0;
      repeat (12) begin
         @(posedge ref_clk_in);
         #1 seen = seen | tamper_irq_out;
      end
      @(posedge ref_clk_in);
      check(32'(seen), 32'(evt & ie_m[0]));
      if (evt) begin
         flag_m = 1;
         dm = '{default: 0};
      end
   endtask
   initial begin
      repeat (50000) @(posedge ref_clk_in);
      bad_count++;
      report_and_stop;
   end
   initial begin
      void'($urandom(98245));
      repeat (8) @(posedge ref_clk_in);
      sys_rst_in <= 1'b0;
      rd_all;
      wr(8'h04, $urandom);
      wr(8'h30, 32'h1);
      rd(8'h04);
      rd(8'h30);
      backup_write_unlock_in <= 1'b1;
      for (int i = 1; i <= 47; i++) if (i <= 10 || i >= 16) wr(8'(i * 4), $urandom);
      wr(8'h38, $urandom);
      wr(8'h2C, $urandom & 32'h7F);
      rd_all;
      wr(8'h34, 32'h4);
      sw_close <= 1'b1;
      sw_rail <= 1'b1;
      expect_event(1'b0);
      check(32'(pin_gpio_free_out), 32'h1);
      wr(8'h30, 32'h1);
      expect_event(1'b1);
      check(32'(pin_gpio_free_out), 32'h0);
      rd_all;
      wr(8'h04, $urandom);
      rd(8'h04);
      wr(8'h34, 32'h5);
      wr(8'h30, 32'h0);
      wr(8'h30, 32'h1);
      expect_event(1'b1);
      sw_close <= 1'b0;
      wr(8'h34, 32'h5);
      expect_event(1'b0);
      sw_close <= 1'b1;
      expect_event(1'b1);
      rd(8'h34);
      sw_close <= 1'b0;
      wr(8'h34, 32'h1);
      wr(8'h30, 32'h0);
      wr(8'h30, 32'h1);
      wr(8'h08, $urandom);
      rd(8'h08);
      sw_close <= 1'b1;
      expect_event(1'b1);
      rd(8'h34);
      wr(8'h34, 32'h5);
      wr(8'h30, 32'h0);
      sw_close <= 1'b0;
      wr(8'h30, 32'h2);
      wr(8'h30, 32'h3);
      expect_event(1'b1);
      sw_close <= 1'b1;
      wr(8'h34, 32'h5);
      expect_event(1'b0);
      main_supply_off_in <= 1'b1;
      sw_close <= 1'b0;
      expect_event(1'b1);
      main_supply_off_in <= 1'b0;
      rd_all;
      wr(8'h30, 32'h2);
      wr(8'h30, 32'h0);
      wr(8'h34, 32'h5);
      wr(8'h2C, 32'h80 | ($urandom & 32'h7F));
      repeat (200) @(posedge ref_clk_in);
      check(32'(period), 32'h40);
      main_supply_off_in <= 1'b1;
      repeat (6) @(posedge ref_clk_in);
      main_supply_off_in <= 1'b0;
      cal_m = cal_m & 32'h37F;
      rd(8'h2C);
      check(32'(tamper_pin_oe_n_out), 32'h1);
      for (int s = 0; s < 2; s++) begin
         wr(8'h2C, 32'(256 + 512 * s));
         for (int p = 0; p < 2; p++) begin
            {rtc_second_pulse_in, rtc_alarm_pulse_in} <= 2'(p + 1);
            @(posedge ref_clk_in);
            {rtc_second_pulse_in, rtc_alarm_pulse_in} <= 2'h0;
            #1 check(32'(tamper_pin_in), 32'(p == s));
            @(posedge ref_clk_in);
            #1 check(32'(tamper_pin_in), 32'h0);
            @(posedge ref_clk_in);
         end
      end
      sys_rst_in <= 1'b1;
      repeat (8) @(posedge ref_clk_in);
      sys_rst_in <= 1'b0;
      {cal_m, ctl_m, ie_m, flag_m} = '0;
      dm = '{default: 0};
      // Fresh window: the largest calibration value holds the divider back first
      wr(8'h2C, 32'hFF);
      edge_n = 0;
      while (!tamper_pin_in && edge_n < 400) begin
         @(posedge ref_clk_in);
         #1 edge_n++;
      end
      @(posedge ref_clk_in);
      // Unslowed, the first rise would come after half a divided period
      check(32'(edge_n > 127 && edge_n < 127 + 64), 32'h1);
      rd_all;
      report_and_stop;
   end
endmodule
`default_nettype wire
